// ### logic/mm_slave_port.sv
// Slave end of a memory-mapped port: word store, pipelined bursts, responses, lock.
// Assumes the master holds its controls steady while waitrequest is high.
//
// Notes on behaviour
// [RL1] Master drives byte address aligned to width.
// [RL2] Slave sees word addresses; 0 is first.
// [RL3] Byte enable n gates write byte n.
// [RL4] Reads ignore lanes; no lanes means all.
// [RL5] Master enables only adjacent byte lanes.
// [RL6] Debug qualifier lets writes land in ROM.
// [RL7] Codes: 00 ok, 10 endpoint, 11 unmapped.
// [RL8] Never read and write response together.
// [RL9] One response per read beat, errors included.
// [RL10] One write response after last beat.
// [RL11] Every write command gets a response.
// [RL12] Read and write data equal power-of-two width.
// [RL13] Minimum signal sets per port direction.
// [RL14] Active-low signals carry an _n suffix.
// [RL15] Master raises lock first, drops on last.
// [RL16] Locked owner keeps grant until lock drops.
// [RL17] Lock-equipped masters never burst.
// [RL18] Read burst of n gives n valids.
// [RL19] Read data never in acceptance cycle.
// [RL20] Read data may return while stalling.
// [RL21] Write response at least one cycle late.
// [RL22] Write taken on last beat, waitrequest low.
// [RL23] Master holds controls while stalled.
// [RL24] Burst counts run from one upward.
// [RL25] Single clock, synchronous reset to idle.
`timescale 1ns/100ps
`include "mm_port_consts.svh"

module mm_slave_port
  import mm_port_pkg::*;
(
  input wire logic clk,
  // [RL14] active-low reset named _n
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [`BURST_W-1:0] burstcount,
  input wire logic [`BE_W-1:0] byteenable,
  // [RL12] one data width both ways
  input wire logic [`DATA_W-1:0] writedata,
  input wire logic debugaccess,
  input wire logic lock,
  input wire logic master_id,
  output logic waitrequest,
  // [RL13] read word, write strobe and data
  output logic [`DATA_W-1:0] readdata,
  output logic readdatavalid,
  output logic [1:0] response,
  output logic writeresponsevalid
);

  state_t state_q;
  state_t state_d;
  logic waitrequest_q;
  logic [`DATA_W-1:0] readdata_q;
  logic readdatavalid_q;
  resp_t response_q;
  logic writeresponsevalid_q;
  logic [`ADDR_W-1:0] addr_q;
  logic [`BURST_W-1:0] beats_left_q;
  resp_t wacc_q;
  logic owner_valid_q;
  logic owner_id_q;
  logic granted;
  logic cmd_seen;
  logic wr_beat;
  logic [`ADDR_W-1:0] beat_waddr;
  resp_t wbeat_code;
  logic mem_we;
  logic [`DATA_W-1:0] mem_rdata;
  logic [`BURST_W-1:0] take_count;

  // ========================================================================
  // Address decode
  // Words above the store are unmapped; the top words behave as ROM, so a
  // write there fails unless the debug qualifier is set.
  function automatic resp_t beat_resp(input logic [`ADDR_W-1:0] a,
                                      input logic is_wr,
                                      input logic dbg);
    resp_t r;
    r = `RESP_SUCCESS;
    // [RL7] response encoding
    if (a[`ADDR_W-1:`IDX_W] != '0)
    begin
      r = `RESP_UNMAPPED;
    end
    // [RL6] debug write to ROM
    else if (is_wr && !dbg && (a[`IDX_W-1:0] >= `ROM_FIRST))
    begin
      r = `RESP_ENDPOINT;
    end
    return r;
  endfunction

  // ========================================================================
  // Arbitration hold
  // [RL16] locked owner keeps grant
  assign granted = !owner_valid_q || (owner_id_q == master_id);
  assign cmd_seen = read || write;

  // [RL24] zero treated as one
  assign take_count = (burstcount == '0) ? `BEATS_ONE : burstcount;

  // ========================================================================
  // Write beats into the store
  // [RL2] word addressing
  assign beat_waddr = (state_q == ST_TAKE) ? address : addr_q;
  // A read in the take cycle wins, so no write beat may land beside it.
  assign wr_beat = write && (((state_q == ST_TAKE) && !read) || (state_q == ST_WBURST));
  assign wbeat_code = beat_resp(beat_waddr, 1'b1, debugaccess);
  // [RL3] only clean beats store
  assign mem_we = wr_beat && (wbeat_code == `RESP_SUCCESS);

  word_store u_store (
    .clk(clk),
    .we(mem_we),
    .waddr(beat_waddr[`IDX_W-1:0]),
    .wdata(writedata),
    .wbe(byteenable),
    .raddr(addr_q[`IDX_W-1:0]),
    .rdata(mem_rdata)
  );

  // ========================================================================
  // Sequencer
  // Waitrequest is high in idle and drops for the take cycle and any later write
  // burst beats only after a granted request is seen. This costs a cycle per command but lets the
  // stall come straight from a flip-flop while still refusing foreign
  // masters during a locked sequence.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (cmd_seen && granted)
        begin
          state_d = ST_TAKE;
        end
      end
      ST_TAKE:
      begin
        if (read)
        begin
          state_d = ST_RD;
        end
        // [RL22] single beat taken now
        else if (write && (take_count == `BEATS_ONE))
        begin
          state_d = ST_WRESP;
        end
        else if (write)
        begin
          state_d = ST_WBURST;
        end
        else
        begin
          state_d = ST_IDLE;
        end
      end
      ST_WBURST:
      begin
        // [RL10] response after last beat
        if (write && (beats_left_q == `BEATS_ONE))
        begin
          state_d = ST_WRESP;
        end
      end
      ST_RD:
      begin
        // [RL18] exactly n beats
        if (beats_left_q == `BEATS_ONE)
        begin
          state_d = ST_IDLE;
        end
      end
      ST_WRESP:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // [RL25] synchronous reset to idle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Stall is held in reset so no master can start a command then.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      waitrequest_q <= 1'b1;
    end
    else
    begin
      waitrequest_q <= !((state_d == ST_TAKE) || (state_d == ST_WBURST));
    end
  end

  // ========================================================================
  // Burst address and beat counting
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_q <= '0;
      beats_left_q <= '0;
    end
    else if (state_q == ST_TAKE && read)
    begin
      addr_q <= address;
      beats_left_q <= take_count;
    end
    else if (wr_beat)
    begin
      addr_q <= `ADDR_W'(beat_waddr + `ADDR_ONE);
      beats_left_q <= (state_q == ST_TAKE) ? `BURST_W'(take_count - `BEATS_ONE)
                                           : `BURST_W'(beats_left_q - `BEATS_ONE);
    end
    else if (state_q == ST_RD)
    begin
      addr_q <= `ADDR_W'(addr_q + `ADDR_ONE);
      beats_left_q <= `BURST_W'(beats_left_q - `BEATS_ONE);
    end
  end

  // ========================================================================
  // Write response accumulation
  // The first failing beat decides the code returned for the whole burst.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wacc_q <= `RESP_SUCCESS;
    end
    else if (wr_beat && (state_q == ST_TAKE))
    begin
      wacc_q <= wbeat_code;
    end
    else if (wr_beat && (wacc_q == `RESP_SUCCESS))
    begin
      wacc_q <= wbeat_code;
    end
  end

  // ========================================================================
  // Read return
  // [RL19] first valid two cycles after take
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      readdatavalid_q <= 1'b0;
      readdata_q <= '0;
    end
    else
    begin
      // [RL20] returns while stalling
      readdatavalid_q <= (state_q == ST_RD);
      if (state_q == ST_RD)
      begin
        // [RL4] lanes ignored on reads
        readdata_q <= mem_rdata;
      end
    end
  end

  // ========================================================================
  // Shared response line
  // Read beats and the write response come from different states, so the
  // shared code line never carries both in one cycle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      response_q <= `RESP_SUCCESS;
      writeresponsevalid_q <= 1'b0;
    end
    else
    begin
      // [RL11] every write answered
      // [RL21] strobe two cycles after the last beat is taken
      writeresponsevalid_q <= (state_q == ST_WRESP);
      // [RL9] code per read beat
      if (state_q == ST_RD)
      begin
        response_q <= beat_resp(addr_q, 1'b0, 1'b0);
      end
      // [RL8] exclusive use of code line
      else if (state_q == ST_WRESP)
      begin
        response_q <= wacc_q;
      end
      else
      begin
        response_q <= `RESP_SUCCESS;
      end
    end
  end

  // ========================================================================
  // Lock ownership
  // Ownership changes only when a command is taken; a taken command with
  // lock low from the owner ends the locked sequence.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      owner_valid_q <= 1'b0;
      owner_id_q <= 1'b0;
    end
    // [RL16] hold until lock drops
    else if (state_q == ST_TAKE && cmd_seen)
    begin
      owner_valid_q <= lock;
      owner_id_q <= master_id;
    end
  end

  assign waitrequest = waitrequest_q;
  assign readdata = readdata_q;
  assign readdatavalid = readdatavalid_q;
  assign response = response_q;
  assign writeresponsevalid = writeresponsevalid_q;

endmodule

// ### inc/mm_port_consts.svh
// Constants for the memory-mapped slave port: widths, map layout, response codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MM_PORT_CONSTS_SVH
`define MM_PORT_CONSTS_SVH

// ==========================================================================
// Widths
`define DATA_W 32
`define BE_W 4
`define ADDR_W 6
`define BURST_W 4
`define IDX_W 4
`define BYTE_W 8

// ==========================================================================
// Map layout, in words
`define WORDS 16
`define ROM_FIRST 4'hc
`define ADDR_ONE 6'h01
`define BEATS_ONE 4'h1

// ==========================================================================
// Two-bit response codes
`define RESP_SUCCESS 2'h0
`define RESP_RESERVED 2'h1
`define RESP_ENDPOINT 2'h2
`define RESP_UNMAPPED 2'h3

`endif

// ### inc/mm_port_pkg.sv
// Types shared by the slave port modules.
// Assumes mm_port_consts.svh is on the include path.
`include "mm_port_consts.svh"

package mm_port_pkg;

  // ========================================================================
  // Port sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_TAKE = 5'h02,
    ST_WBURST = 5'h04,
    ST_RD = 5'h08,
    ST_WRESP = 5'h10
  } state_t;

  typedef logic [1:0] resp_t;

endpackage

// ### logic/word_store.sv
// Word-wide storage with per-byte write lanes and a combinational read.
// Assumes a single clock; contents are undefined until written.
`timescale 1ns/100ps
`include "mm_port_consts.svh"

module word_store
  import mm_port_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [`IDX_W-1:0] waddr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic [`BE_W-1:0] wbe,
  input wire logic [`IDX_W-1:0] raddr,
  output logic [`DATA_W-1:0] rdata
);

  logic [`DATA_W-1:0] mem [`WORDS];

  // ========================================================================
  // Byte-lane writes
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      for (int i = 0; i < `BE_W; i++)
      begin
        if (wbe[i])
        begin
          mem[waddr][i*`BYTE_W +: `BYTE_W] <= wdata[i*`BYTE_W +: `BYTE_W];
        end
      end
    end
  end

  assign rdata = mem[raddr];

endmodule

// ### dv/mm_port_chk.sv
// Checker for the slave port's response timing and codes.
// Assumes a bind onto mm_slave_port, one clock, synchronous reset.
`timescale 1ns/100ps
module mm_port_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] burstcount,
  input wire logic waitrequest,
  input wire logic readdatavalid,
  input wire logic [1:0] response,
  input wire logic writeresponsevalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Sequences
  sequence rd_take;
    read && !waitrequest;
  endsequence
  sequence rd_take3;
    read && !waitrequest && burstcount == 4'h3;
  endsequence
  sequence wr_take1;
    write && !read && !waitrequest && burstcount == 4'h1;
  endsequence

  // ==========================================================================
  // Assertions
  chk_resp_exclusive: assert property (
    !(readdatavalid && writeresponsevalid))
    else $error("read and write response together");
  chk_code_legal: assert property (
    (readdatavalid || writeresponsevalid) |-> response != 2'h1)
    else $error("reserved response code");
  chk_code_quiet: assert property (
    !readdatavalid && !writeresponsevalid |-> response == 2'h0)
    else $error("response code without strobe");
  chk_rd_latency: assert property (
    rd_take |-> !readdatavalid ##1 !readdatavalid ##1 readdatavalid)
    else $error("read data latency wrong");
  chk_rd_beats: assert property (
    rd_take3 |-> ##2 readdatavalid [*3] ##1 !readdatavalid)
    else $error("read burst pulse count wrong");
  chk_wr_single: assert property (
    wr_take1 |-> !writeresponsevalid ##1 !writeresponsevalid ##1 writeresponsevalid)
    else $error("write response missing");
  chk_wresp_cause: assert property (
    writeresponsevalid |-> $past(write, 2) && !$past(waitrequest, 2))
    else $error("write response without taken beat");
  chk_wresp_once: assert property (
    writeresponsevalid |=> !writeresponsevalid)
    else $error("write response repeated");
  // Own disable so the reset values themselves are checked.
  chk_reset_idle: assert property (
    disable iff (1'b0) !rst_n |=> waitrequest && !readdatavalid && !writeresponsevalid
      && response == 2'h0)
    else $error("port not idle after reset");
endmodule

// ### dv/mm_master.sv
// Bus master model: issues reads and writes, logs returned responses.
// Assumes one clock; drives at falling edges and holds while stalled.
`timescale 1ns/100ps
module mm_master
(
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  input wire logic readdatavalid,
  input wire logic [1:0] response,
  input wire logic writeresponsevalid,
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [3:0] burstcount,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  output logic debugaccess,
  output logic lock,
  output logic master_id
);
  logic [33:0] rq[$];
  logic [1:0] wq[$];

  initial
  begin
    {address, read, write, burstcount, byteenable} = '0;
    {writedata, debugaccess, lock, master_id} = '0;
  end

  // Responses stand from one rising edge to the next, so the falling edge
  // sees them settled.
  always @(negedge clk)
  begin
    if (readdatavalid)
      rq.push_back({response, readdata});
    if (writeresponsevalid)
      wq.push_back(response);
  end

  // ==========================================================================
  // One command; gives up after lim edges so a stall can be measured.
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [3:0] n,
    input logic [3:0] be, input logic [31:0] d, input logic dbg, input logic lk,
    input logic id, input int lim, output int acc);
    int t;
    int beats;
    logic hit;
    acc = 0;
    t = 0;
    beats = rd ? 1 : int'(n);
    @(negedge clk);
    {address, burstcount, byteenable, writedata} = {a, n, be, d};
    {read, write, debugaccess, master_id} = {rd, !rd, dbg, id};
    lock = lk && n == 4'h1;
    while (acc < beats && t < lim)
    begin
      // The stall comes from a flop, so its level here is what the next edge sees.
      hit = !waitrequest;
      @(posedge clk);
      t++;
      if (hit)
        acc++;
      @(negedge clk);
      if (acc < beats && t < lim)
        writedata = d + 32'(acc);
    end
    {read, write, lock} = 3'h0;
    address = ~a;
    writedata = ~writedata;
  endtask
endmodule

// ### dv/mm_slave_port_protocol_bench.sv
// Self-checking bench for the slave port: lanes, bursts, faults, lock.
// Assumes the master model and checker files compile ahead of this one.
`timescale 1ns/100ps
module mm_slave_port_protocol_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] address;
  logic [3:0] burstcount, byteenable;
  logic [31:0] writedata, readdata;
  logic [1:0] response;
  logic read, write, debugaccess, lock, master_id;
  logic waitrequest, readdatavalid, writeresponsevalid;
  int n_fail = 0;
  int comparisons = 0;

  mm_slave_port u_dut (.clk, .rst_n, .address, .read, .write, .burstcount,
    .byteenable, .writedata, .debugaccess, .lock, .master_id, .waitrequest,
    .readdata, .readdatavalid, .response, .writeresponsevalid);
  mm_master u_m (.clk, .waitrequest, .readdata, .readdatavalid, .response,
    .writeresponsevalid, .address, .read, .write, .burstcount, .byteenable,
    .writedata, .debugaccess, .lock, .master_id);

  always #20 clk = ~clk;

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input string name, input int nr, input int nw);
    for (int i = 0; i < 40 && (u_m.rq.size() < nr || u_m.wq.size() < nw); i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    check("count", 34'(u_m.rq.size()) + 34'(u_m.wq.size()), 34'(nr + nw));
    $display("test %s finished", name);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_lanes();
    int acc;
    u_m.xfer(0, 6'h01, 4'h1, 4'hf, 32'h11223344, 0, 0, 0, 200, acc);
    u_m.xfer(0, 6'h01, 4'h1, 4'h6, 32'haabbccdd, 0, 0, 0, 200, acc);
    u_m.xfer(1, 6'h01, 4'h1, 4'h1, 32'h0, 0, 0, 0, 200, acc);
    settle("lanes", 1, 2);
    check("wresp", u_m.wq.pop_front(), 2'h0);
    check("wresp", u_m.wq.pop_front(), 2'h0);
    check("word1", u_m.rq.pop_front(), {2'h0, 32'h11bbcc44});
  endtask

  task automatic t_burst();
    int acc;
    u_m.xfer(0, 6'h04, 4'h3, 4'hf, 32'h5a000000, 0, 0, 0, 200, acc);
    u_m.xfer(1, 6'h04, 4'h3, 4'hf, 32'h0, 0, 0, 0, 200, acc);
    settle("burst", 3, 1);
    check("burst wresp", u_m.wq.pop_front(), 2'h0);
    for (int i = 0; i < 3; i++)
      check("burst rd", u_m.rq.pop_front(), {2'h0, 32'h5a000000 + 32'(i)});
  endtask

  task automatic t_faults();
    int acc;
    u_m.xfer(0, 6'h0d, 4'h1, 4'hf, 32'hc0de0001, 1, 0, 0, 200, acc);
    u_m.xfer(0, 6'h0d, 4'h1, 4'hf, 32'hdead0002, 0, 0, 0, 200, acc);
    u_m.xfer(0, 6'h21, 4'h1, 4'hf, 32'h0, 0, 0, 0, 200, acc);
    u_m.xfer(1, 6'h0d, 4'h1, 4'hf, 32'h0, 0, 0, 0, 200, acc);
    u_m.xfer(1, 6'h21, 4'h1, 4'hf, 32'h0, 0, 0, 0, 200, acc);
    settle("faults", 2, 3);
    check("rom dbg wr", u_m.wq.pop_front(), 2'h0);
    check("rom wr", u_m.wq.pop_front(), 2'h2);
    check("unmapped wr", u_m.wq.pop_front(), 2'h3);
    check("rom rd", u_m.rq.pop_front(), {2'h0, 32'hc0de0001});
    check("unmapped rd", u_m.rq.pop_front() >> 32, 34'h3);
  endtask

  task automatic t_lock();
    int acc;
    u_m.xfer(1, 6'h01, 4'h1, 4'hf, 32'h0, 0, 1, 0, 200, acc);
    // The intruder gives up after eight stalled edges on purpose.
    u_m.xfer(1, 6'h02, 4'h1, 4'hf, 32'h0, 0, 0, 1, 8, acc);
    check("intruder stalled", 34'(acc), 34'h0);
    u_m.xfer(1, 6'h01, 4'h1, 4'hf, 32'h0, 0, 0, 0, 200, acc);
    u_m.xfer(1, 6'h02, 4'h1, 4'hf, 32'h0, 0, 0, 1, 200, acc);
    check("intruder served", 34'(acc), 34'h1);
    settle("lock", 3, 0);
    for (int i = 0; i < 3; i++)
      check("lock rd", u_m.rq.pop_front() >> 32, 34'h0);
  endtask

  task automatic t_reset();
    int acc;
    u_m.xfer(1, 6'h04, 4'h3, 4'hf, 32'h0, 0, 0, 0, 200, acc);
    // Reset lands on the edge after the take, before any beat is returned.
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("flushed beats", 34'(u_m.rq.size()), 34'h0);
    u_m.xfer(1, 6'h05, 4'h0, 4'hf, 32'h0, 0, 0, 0, 200, acc);
    settle("reset", 1, 0);
    check("zero count rd", u_m.rq.pop_front(), {2'h0, 32'h5a000001});
  endtask

  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_lanes();
    t_burst();
    t_faults();
    t_lock();
    t_reset();
    end_sim();
  end

  // The tests need about a hundred cycles; 3000 leaves ample margin.
  initial
  begin
    #120000;
    n_fail++;
    end_sim();
  end
endmodule

bind mm_slave_port mm_port_chk u_chk (.clk, .rst_n, .read, .write, .burstcount,
  .waitrequest, .readdatavalid, .response, .writeresponsevalid);
